// >>> inc/alarm_pkg.sv
package alarm_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LANES  = 8;

  localparam logic [11:0] ADDR_SUMMARY = 12'h2C0;
  localparam logic [11:0] ADDR_FLAGS   = 12'h2C1;
  localparam logic [11:0] ADDR_MASKS   = 12'h2C2;
  localparam logic [11:0] ADDR_LANES   = 12'h2C4;

  localparam int BIT_SUMMARY = 0;
  localparam int BIT_FIFO    = 5;
  localparam int BIT_PLL     = 4;
  localparam int BIT_LINK    = 3;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_RSVD1   = 1;
  localparam int BIT_CLK     = 0;

  localparam logic [7:0] FLAGS_RESET = 8'h3F;
  localparam logic [7:0] MASKS_RESET = 8'h3F;
  localparam logic [7:0] LANES_RESET = 8'hFF;
  localparam logic [7:0] ALARM_BITS  = 8'h3D;

  typedef enum logic [0:0] {
    ENC_8B10B  = 1'b0,
    ENC_64B66B = 1'b1
  } link_enc_t;
endpackage

// >>> verilog/alarm_status_aggregator.sv
`timescale 1ns/1ps
// Operation
// RQ1: Summary bit 0 reads 1 when any unmasked alarm flag is set.
// RQ2: Output selection routes summary bit onto the calibration status pin.
// RQ3: FIFO flag bit 5 sets on any active lane FIFO over/underflow.
// RQ4: PLL flag bit 4 sets while serializer PLL is unlocked.
// RQ5: In 8b/10b, link flag bit 3 sets when enabled but not in data state.
// RQ6: In 64b/66b, link flag sets at link start and on any realignment.
// RQ7: Realign flag bit 2 sets when SYSREF realigns internal clocks.
// RQ8: Clock flag bit 0 sets when A/B and C/D dividers disagree.
// RQ9: Writing 1 clears a flag bit; writing 0 leaves it.
// RQ10: Reset sets every alarm flag, reading back 0x3F.
// RQ11: Software treats non-clock alarms as undefined while link disabled.
// RQ12: Mask bit 1 excludes a source from summary; masks reset to ones.
// RQ13: Software writes defaults into reserved mask bits.
// RQ14: Per-lane FIFO alarm register resets to all ones.
// RQ15: Lane i fault sets lane bit i; write 1 clears it. Code sets the bit only while lane_active_in[i] is high.
// RQ16: Writing 1 to FIFO flag clears all per-lane bits.
// RQ17: A set in the same cycle wins over a clearing write.
module alarm_status_aggregator
  import alarm_pkg::*;
#(
  parameter int N_LANES = LANES
) (
  // Clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               rst_n_in,
  // Register access port
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic [ADDR_W-1:0]  reg_addr_in,
  input  wire logic [DATA_W-1:0]  reg_wdata_in,
  output logic      [DATA_W-1:0]  reg_rdata_out,
  output logic                    reg_rvalid_out,
  // Alarm sources
  input  wire logic [N_LANES-1:0] lane_active_in,
  input  wire logic [N_LANES-1:0] lane_fifo_fault_in,
  input  wire logic               pll_locked_in,
  input  wire logic               serial_link_enable_in,
  input  wire logic               link_encoding_in,
  input  wire logic               encoded_data_state_in,
  input  wire logic               link_realign_in,
  input  wire logic               sysref_realign_in,
  input  wire logic               divider_mismatch_in,
  // Calibration status pin
  input  wire logic               cal_status_sel_alarm_in,
  input  wire logic               cal_status_in,
  output logic                    cal_status_pin_out
);

  // Stored alarm flags, one flop per source
  logic                        lane_fifo_fault_flag_r;
  logic                        serializer_pll_unlock_flag_r;
  logic                        link_not_up_flag_r;
  logic                        clock_realign_flag_r;
  logic                        divider_mismatch_flag_r;
  logic [7:0]                  flags_vec;

  // Mask register and its named fields
  logic [7:0]                  masks_r;
  logic                        lane_fifo_fault_mask;
  logic                        serializer_pll_unlock_mask;
  logic                        link_not_up_mask;
  logic                        clock_realign_mask;
  logic                        divider_mismatch_mask;

  // Per-lane and summary state
  logic [N_LANES-1:0]          lanes_vec;
  logic                        summary_r;
  logic                        summary_nxt;
  logic                        link_en_d_r;

  // Register decode
  logic                        wr_flags;
  logic                        wr_masks;
  logic                        wr_lanes;
  logic [DATA_W-1:0]           rdata_nxt;

  // Hardware causes
  logic [N_LANES-1:0]          lane_hit;
  logic                        fifo_set;
  logic                        pll_set;
  logic                        link_set;
  logic                        realign_set;
  logic                        clk_set;

  // Software clear strobes
  logic                        fifo_clr;
  logic                        pll_clr;
  logic                        link_clr;
  logic                        realign_clr;
  logic                        clk_clr;
  logic                        lane_clr_all;

  // Writes to the summary address decode to nothing: it is read-only
  assign wr_flags = reg_wr_in && (reg_addr_in == ADDR_FLAGS);
  assign wr_masks = reg_wr_in && (reg_addr_in == ADDR_MASKS);
  assign wr_lanes = reg_wr_in && (reg_addr_in == ADDR_LANES);

  // Write-one-to-clear strobes per flag
  assign fifo_clr     = wr_flags && reg_wdata_in[BIT_FIFO]; // RQ9
  assign pll_clr      = wr_flags && reg_wdata_in[BIT_PLL]; // RQ9
  assign link_clr     = wr_flags && reg_wdata_in[BIT_LINK]; // RQ9
  assign realign_clr  = wr_flags && reg_wdata_in[BIT_REALIGN]; // RQ9
  assign clk_clr      = wr_flags && reg_wdata_in[BIT_CLK]; // RQ9
  assign lane_clr_all = fifo_clr; // RQ16

  // Only faults of lanes in use count
  assign lane_hit    = lane_fifo_fault_in & lane_active_in; // RQ3
  assign fifo_set    = |lane_hit; // RQ3
  assign pll_set     = !pll_locked_in; // RQ4
  assign realign_set = sysref_realign_in; // RQ7
  assign clk_set     = divider_mismatch_in; // RQ8

  // Link flag cause depends on encoding mode
  always_comb begin
    if (link_encoding_in == ENC_8B10B) begin
      link_set = serial_link_enable_in && !encoded_data_state_in; // RQ5
    end else begin
      // No data state here; start-up and realignment stand in for it
      link_set = serial_link_enable_in && (!link_en_d_r || link_realign_in); // RQ6
    end
  end

  // Starts low, so a link enabled out of reset alarms once
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      link_en_d_r <= 1'b0;
    end else begin
      link_en_d_r <= serial_link_enable_in;
    end
  end

  // Set is tested first so a live cause survives a clearing write
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      lane_fifo_fault_flag_r <= FLAGS_RESET[BIT_FIFO]; // RQ10
    end else if (fifo_set) begin
      lane_fifo_fault_flag_r <= 1'b1; // RQ3 RQ17
    end else if (fifo_clr) begin
      lane_fifo_fault_flag_r <= 1'b0; // RQ9
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      serializer_pll_unlock_flag_r <= FLAGS_RESET[BIT_PLL]; // RQ10
    end else if (pll_set) begin
      serializer_pll_unlock_flag_r <= 1'b1; // RQ4 RQ17
    end else if (pll_clr) begin
      serializer_pll_unlock_flag_r <= 1'b0; // RQ9
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      link_not_up_flag_r <= FLAGS_RESET[BIT_LINK]; // RQ10
    end else if (link_set) begin
      link_not_up_flag_r <= 1'b1; // RQ5 RQ6 RQ17
    end else if (link_clr) begin
      link_not_up_flag_r <= 1'b0; // RQ9
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      clock_realign_flag_r <= FLAGS_RESET[BIT_REALIGN]; // RQ10
    end else if (realign_set) begin
      clock_realign_flag_r <= 1'b1; // RQ7 RQ17
    end else if (realign_clr) begin
      clock_realign_flag_r <= 1'b0; // RQ9
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      divider_mismatch_flag_r <= FLAGS_RESET[BIT_CLK]; // RQ10
    end else if (clk_set) begin
      divider_mismatch_flag_r <= 1'b1; // RQ8 RQ17
    end else if (clk_clr) begin
      divider_mismatch_flag_r <= 1'b0; // RQ9
    end
  end

  // Reserved bit 1 reads its default one, bits 7:6 read zero
  always_comb begin
    flags_vec              = '0;
    flags_vec[BIT_FIFO]    = lane_fifo_fault_flag_r;
    flags_vec[BIT_PLL]     = serializer_pll_unlock_flag_r;
    flags_vec[BIT_LINK]    = link_not_up_flag_r;
    flags_vec[BIT_REALIGN] = clock_realign_flag_r;
    flags_vec[BIT_RSVD1]   = FLAGS_RESET[BIT_RSVD1];
    flags_vec[BIT_CLK]     = divider_mismatch_flag_r;
  end

  // Reserved fields stored as written; software keeps them at default
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      masks_r <= MASKS_RESET; // RQ12
    end else if (wr_masks) begin
      masks_r <= reg_wdata_in;
    end
  end

  assign lane_fifo_fault_mask       = masks_r[BIT_FIFO];
  assign serializer_pll_unlock_mask = masks_r[BIT_PLL];
  assign link_not_up_mask           = masks_r[BIT_LINK];
  assign clock_realign_mask         = masks_r[BIT_REALIGN];
  assign divider_mismatch_mask      = masks_r[BIT_CLK];

  // Per-lane sticky bits; a live fault re-sets a bit at once
  for (genvar i = 0; i < N_LANES; i++) begin : g_lane
    logic lane_r;

    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        lane_r <= LANES_RESET[i]; // RQ14
      end else if (lane_hit[i]) begin
        lane_r <= 1'b1; // RQ15 RQ17
      end else if (lane_clr_all || (wr_lanes && reg_wdata_in[i])) begin
        lane_r <= 1'b0; // RQ15 RQ16
      end
    end

    assign lanes_vec[i] = lane_r;
  end

  // Reserved flag bits never reach the summary
  always_comb begin
    summary_nxt = 1'b0;
    if (lane_fifo_fault_flag_r && !lane_fifo_fault_mask) begin
      summary_nxt = 1'b1; // RQ1 RQ12
    end
    if (serializer_pll_unlock_flag_r && !serializer_pll_unlock_mask) begin
      summary_nxt = 1'b1; // RQ1 RQ12
    end
    if (link_not_up_flag_r && !link_not_up_mask) begin
      summary_nxt = 1'b1; // RQ1 RQ12
    end
    if (clock_realign_flag_r && !clock_realign_mask) begin
      summary_nxt = 1'b1; // RQ1 RQ12
    end
    if (divider_mismatch_flag_r && !divider_mismatch_mask) begin
      summary_nxt = 1'b1; // RQ1 RQ12
    end
  end

  // Summary from stored flags; one cycle behind the flags
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      summary_r <= 1'b0;
    end else begin
      summary_r <= summary_nxt; // RQ1
    end
  end

  // Registered pin adds one more cycle of latency to the alarm
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cal_status_pin_out <= 1'b0;
    end else begin
      cal_status_pin_out <= cal_status_sel_alarm_in ? summary_r : cal_status_in; // RQ2
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    unique case (reg_addr_in)
      ADDR_SUMMARY: rdata_nxt = {7'h00, summary_r};
      ADDR_FLAGS:   rdata_nxt = flags_vec;
      ADDR_MASKS:   rdata_nxt = masks_r;
      ADDR_LANES:   rdata_nxt = DATA_W'(lanes_vec);
      default:      rdata_nxt = '0;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
    end
  end

endmodule

// >>> sim/alarm_props_properties.sv
`timescale 1ns/1ps
module alarm_props import alarm_pkg::*; #(parameter int N_LANES = LANES) (
  input wire logic sys_clk_in, rst_n_in, reg_rd_in, pll_locked_in, divider_mismatch_in, sysref_realign_in,
  input wire logic cal_status_sel_alarm_in, cal_status_in, cal_status_pin_out,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [N_LANES-1:0] lane_active_in, lane_fifo_fault_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p(c, a, e);
    c ##1 (reg_rd_in && reg_addr_in == a) |=> e;
  endproperty
  AST_SUM: assert property (p(1'b1, ADDR_SUMMARY, !reg_rdata_out[7:1])) else $error("sum");
  AST_RSVD: assert property (p(1'b1, ADDR_FLAGS, !reg_rdata_out[7:6] && reg_rdata_out[1])) else $error("rsv");
  AST_PLL: assert property (p(!pll_locked_in, ADDR_FLAGS, reg_rdata_out[BIT_PLL])) else $error("pll");
  AST_CLK: assert property (p(divider_mismatch_in, ADDR_FLAGS, reg_rdata_out[BIT_CLK])) else $error("clk");
  AST_SYNC: assert property (p(sysref_realign_in, ADDR_FLAGS, reg_rdata_out[BIT_REALIGN])) else $error("syn");
  AST_FIFO: assert property (p(|(lane_active_in & lane_fifo_fault_in), ADDR_FLAGS, reg_rdata_out[BIT_FIFO]))
    else $error("fifo");
  AST_LANE: assert property (p(lane_active_in[3] && lane_fifo_fault_in[3], ADDR_LANES, reg_rdata_out[3]))
    else $error("lane");
  AST_PIN: assert property (!cal_status_sel_alarm_in |=> cal_status_pin_out == $past(cal_status_in))
    else $error("pin");
  cover property (cal_status_sel_alarm_in && cal_status_pin_out);
  cover property (reg_rd_in && reg_addr_in == ADDR_LANES);
  cover property (|lane_fifo_fault_in);
endmodule

bind alarm_status_aggregator alarm_props #(.N_LANES(N_LANES)) u_props (.*);

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import alarm_pkg::*;
  logic clk = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, cal_status_sel_alarm_in = 0, cal_status_pin_out;
  logic reg_rvalid_out, serial_link_enable_in = 1, link_encoding_in = 0, link_realign_in = 0;
  logic [11:0] reg_addr_in = 0;
  logic [7:0] reg_wdata_in = 0, lane_active_in = 8'h0C, lane_fifo_fault_in = 0, reg_rdata_out;
  logic [3:0] src = 4'hC;
  wire pll_locked_in, encoded_data_state_in, sysref_realign_in, divider_mismatch_in;
  int n_fail = 0, n_tests = 0;
  // Idle pattern: locked, link in data state
  assign {pll_locked_in, encoded_data_state_in, sysref_realign_in, divider_mismatch_in} = src;
  always #2 clk = ~clk;
  // Normal status held low so only the routed alarm can raise the pin
  alarm_status_aggregator DUT (.sys_clk_in(clk), .cal_status_in(1'b0), .*);
  task chk(input string nm, input logic [7:0] s, e);
    n_tests++;
    n_fail += int'(s !== e);
    if (s !== e) $display("[ERR] %s exp %h got %h", nm, e, s);
  endtask
  task x(input bit wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) #1 {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {wr, !wr, a, d};
    @(posedge clk) #1 {reg_wr_in, reg_rd_in} = 2'b00;
    if (!wr) chk("rdata", reg_rdata_out, d);
    chk("rvalid", {7'h00, reg_rvalid_out}, {7'h00, !wr});
  endtask
  task stop_test;
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n_in = 1;
    x(0, ADDR_FLAGS, 8'h3F);
    x(0, ADDR_LANES, 8'hFF);
    x(0, 12'h2C3, 8'h00);
    x(1, ADDR_FLAGS, 8'h3F);
    for (int i = 0; i < 4; i++) begin
      src = 4'hC ^ (4'h8 >> i);
      x(0, ADDR_FLAGS, i == 3 ? 8'h03 : 8'h02 | 8'h10 >> i);
      src = 4'hC;
      x(1, ADDR_FLAGS, 8'h3F);
    end
    link_encoding_in = 1;
    link_realign_in = 1;
    x(0, ADDR_FLAGS, 8'h0A);
    link_realign_in = 0;
    serial_link_enable_in = 0;
    x(1, ADDR_FLAGS, 8'h3F);
    serial_link_enable_in = 1;
    x(0, ADDR_FLAGS, 8'h0A);
    link_encoding_in = 0;
    x(1, ADDR_FLAGS, 8'h3F);
    lane_fifo_fault_in = 8'h09;
    x(0, ADDR_LANES, 8'h08);
    x(0, ADDR_FLAGS, 8'h22);
    src = 4'hD;
    x(1, ADDR_MASKS, 8'h3E);
    x(1, ADDR_FLAGS, 8'h01);
    x(0, ADDR_SUMMARY, 8'h01);
    cal_status_sel_alarm_in = 1;
    src = 4'h4;
    x(1, ADDR_FLAGS, 8'h01);
    chk("pin", {7'h00, cal_status_pin_out}, 8'h01);
    x(0, ADDR_SUMMARY, 8'h00);
    chk("pin", {7'h00, cal_status_pin_out}, 8'h00);
    stop_test;
  end
  initial begin
    #2000 n_fail++;
    stop_test;
  end
endmodule
